/* File: rtl/sdc_pkg.sv */
/*
  Constants, register map and carrier types for the strobe delay and
  FIFO control block of one DDR strobe group.
  Assumes a 40 MHz system clock and a classic Wishbone slave port.
*/
`default_nettype none
package sdc_pkg;
  // register byte offsets
  localparam logic [3:0] OFS_CTRL = 4'h0;
  localparam logic [3:0] OFS_STATUS = 4'h4;
  localparam logic [3:0] OFS_TAPS = 4'h8;
  localparam logic [3:0] OFS_CODE = 4'hC;
  // control fields
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_BCLR_BIT = 1;
  localparam int CTRL_SWCODE_BIT = 2;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0001;
  localparam logic [8:0] CODE_RESET = 9'h020;
  // status fields
  localparam int ST_RDPTR_POS = 0;
  localparam int ST_WRPTR_POS = 4;
  localparam int ST_BURST_BIT = 8;
  localparam int ST_RDCARRY_BIT = 9;
  localparam int ST_WRCARRY_BIT = 10;
  // taps register fields
  localparam int TAP_RD_POS = 0;
  localparam int TAP_WD_POS = 4;
  localparam int TAP_WS_POS = 8;
  // delay line geometry
  localparam int LINE_LEN = 16;
  localparam logic [3:0] MARGIN_MID = 4'h8;
  localparam logic [3:0] TAP_MAX = 4'hF;
  localparam int PTR_W = 3;
  localparam int GROUP_PINS = 16;
  localparam int STROBE_PINS = 2;
  localparam int DATA_PINS = GROUP_PINS - STROBE_PINS;
  localparam int READ_W = 2;
  localparam int PULSE_SEL_W = 3;
  localparam int PULSE_DEPTH = 8;
  localparam int CODE_W = 9;
  // one margin-control input group
  typedef struct packed {
    logic load_n;
    logic step;
    logic dir;
  } sdc_margin_t;
endpackage
`default_nettype wire

/* File: rtl/sdc_strobe_delay_control_block.sv */
/*
  Strobe delay and FIFO control for one DDR strobe group: read capture
  clock, write strobe and data clocks, write leveling, margin controls,
  FIFO pointers for every data pin cell and read burst framing.
  Assumes strobe, edge clock and controller inputs synchronous to CLK,
  a master delay lock loop code on DELAY_SETTING_IN, Wishbone classic.
*/
`default_nettype none

// margin counter: load to centre, step on a rising step edge in the given direction
module sdc_margin_ctr (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire sdc_pkg::sdc_margin_t ctl,
  output logic [3:0] value_reg,
  output logic carry_reg
);
  logic step_prev_reg;
  logic step_rise;
  assign step_rise = ctl.step & ~step_prev_reg;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      step_prev_reg <= 1'b0;
    end else if (ce) begin
      step_prev_reg <= ctl.step;
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      value_reg <= sdc_pkg::MARGIN_MID;
      carry_reg <= 1'b0;
    end else if (ce) begin
      carry_reg <= 1'b0;
      if (!ctl.load_n) begin
        value_reg <= sdc_pkg::MARGIN_MID;
      end else if (step_rise) begin
        if (ctl.dir) begin
          if (value_reg == sdc_pkg::TAP_MAX) begin
            carry_reg <= 1'b1;
          end else begin
            value_reg <= value_reg + 4'h1;
          end
        end else begin
          if (value_reg == 4'h0) begin
            carry_reg <= 1'b1;
          end else begin
            value_reg <= value_reg - 4'h1;
          end
        end
      end
    end
  end
endmodule // sdc_margin_ctr

module sdc_strobe_delay_control_block (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic CE,
  input wire logic STROBE,
  input wire logic EDGE_CLK,
  input wire logic [1:0] READ,
  input wire logic [2:0] READ_PULSE_SEL,
  input wire sdc_pkg::sdc_margin_t RD_MARGIN,
  input wire sdc_pkg::sdc_margin_t WR_MARGIN,
  input wire sdc_pkg::sdc_margin_t WLVL,
  input wire logic [8:0] DELAY_SETTING_IN,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [3:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK_O,
  output logic READ_CAPTURE_CLK,
  output logic WRITE_STROBE_CLK,
  output logic WRITE_DATA_CLK,
  output logic [2:0] FIFO_RD_PTR,
  output logic [2:0] FIFO_WR_PTR,
  output logic [41:0] PIN_RD_PTR,
  output logic [41:0] PIN_WR_PTR,
  output logic READ_VALID_START,
  output logic BURST_SEEN,
  output logic RD_DELAY_CARRY,
  output logic WR_DELAY_CARRY,
  output logic [8:0] DELAY_SETTING_OUT
);
  logic [31:0] ctrl_reg;
  logic [8:0] sw_code_reg;
  logic [15:0] strobe_line_reg;
  logic [15:0] edge_line_reg;
  logic [3:0] rd_adj, wr_adj, wl_adj;
  logic rd_carry, wr_carry;
  logic [8:0] code;
  logic [3:0] rd_tap, wd_tap, ws_tap;
  logic cap_rise, edge_rise;
  logic [7:0] read_pipe_reg;
  logic window, window_prev_reg, armed_reg;
  logic wb_req, wb_wr;
  logic burst_clr;

  // tap = quarter of code plus margin offset around centre, clamped to the line
  function automatic logic [3:0] tap_of(input logic [8:0] c, input logic [3:0] a,
                                        input logic [4:0] b);
    logic [9:0] s;
    s = {3'h0, c[8:2]} + {6'h00, a} + {5'h00, b};
    if (s < {5'h00, sdc_pkg::MARGIN_MID, 1'b0}) begin
      tap_of = 4'h0;
    end else if (s - {5'h00, sdc_pkg::MARGIN_MID, 1'b0} > {6'h00, sdc_pkg::TAP_MAX}) begin
      tap_of = sdc_pkg::TAP_MAX;
    end else begin
      tap_of = 4'(s - {5'h00, sdc_pkg::MARGIN_MID, 1'b0});
    end
  endfunction

  sdc_margin_ctr u_rd_margin (.clk(CLK), .rst_n(RST_N), .ce(CE), .ctl(RD_MARGIN),
    .value_reg(rd_adj), .carry_reg(rd_carry));
  sdc_margin_ctr u_wr_margin (.clk(CLK), .rst_n(RST_N), .ce(CE), .ctl(WR_MARGIN),
    .value_reg(wr_adj), .carry_reg(wr_carry));
  sdc_margin_ctr u_wlvl (.clk(CLK), .rst_n(RST_N), .ce(CE), .ctl(WLVL),
    .value_reg(wl_adj), .carry_reg());

  assign code = ctrl_reg[sdc_pkg::CTRL_SWCODE_BIT] ? sw_code_reg : DELAY_SETTING_IN;
  assign rd_tap = tap_of(code, rd_adj, {1'b0, sdc_pkg::MARGIN_MID});
  assign ws_tap = tap_of(9'h000, wl_adj, {1'b0, sdc_pkg::MARGIN_MID});
  assign wd_tap = tap_of(code, wr_adj, {1'b0, ws_tap} + {1'b0, sdc_pkg::MARGIN_MID});

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      strobe_line_reg <= 16'h0000;
      edge_line_reg <= 16'h0000;
    end else if (CE) begin
      strobe_line_reg <= {strobe_line_reg[14:0], STROBE};
      edge_line_reg <= {edge_line_reg[14:0], EDGE_CLK};
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      READ_CAPTURE_CLK <= 1'b0;
      WRITE_STROBE_CLK <= 1'b0;
      WRITE_DATA_CLK <= 1'b0;
      DELAY_SETTING_OUT <= 9'h000;
      RD_DELAY_CARRY <= 1'b0;
      WR_DELAY_CARRY <= 1'b0;
    end else if (CE) begin
      READ_CAPTURE_CLK <= ctrl_reg[sdc_pkg::CTRL_EN_BIT] & strobe_line_reg[rd_tap];
      WRITE_STROBE_CLK <= edge_line_reg[ws_tap];
      WRITE_DATA_CLK <= edge_line_reg[wd_tap];
      DELAY_SETTING_OUT <= code;
      RD_DELAY_CARRY <= rd_carry;
      WR_DELAY_CARRY <= wr_carry;
    end
  end

  logic cap_prev_reg, edge_prev_reg;
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      cap_prev_reg <= 1'b0;
      edge_prev_reg <= 1'b0;
    end else if (CE) begin
      cap_prev_reg <= READ_CAPTURE_CLK;
      edge_prev_reg <= EDGE_CLK;
    end
  end
  assign cap_rise = READ_CAPTURE_CLK & ~cap_prev_reg;
  assign edge_rise = EDGE_CLK & ~edge_prev_reg;

  // write side on delayed strobe, read side on edge clock
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      FIFO_WR_PTR <= 3'h0;
      FIFO_RD_PTR <= 3'h0;
    end else if (CE) begin
      // one step per own-clock cycle, wrap at eight
      if (cap_rise) begin
        FIFO_WR_PTR <= FIFO_WR_PTR + 3'h1;
      end
      if (edge_rise) begin
        FIFO_RD_PTR <= FIFO_RD_PTR + 3'h1;
      end
    end
  end

  // same pointers to every data pin cell
  // data pins only, strobe pair excluded
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      PIN_WR_PTR <= 42'h000_0000_0000;
      PIN_RD_PTR <= 42'h000_0000_0000;
    end else if (CE) begin
      PIN_WR_PTR <= {sdc_pkg::DATA_PINS{cap_rise ? FIFO_WR_PTR + 3'h1 : FIFO_WR_PTR}};
      PIN_RD_PTR <= {sdc_pkg::DATA_PINS{edge_rise ? FIFO_RD_PTR + 3'h1 : FIFO_RD_PTR}};
    end
  end

  // read indication delayed by the pulse selection
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      read_pipe_reg <= 8'h00;
      window_prev_reg <= 1'b0;
    end else if (CE) begin
      read_pipe_reg <= {read_pipe_reg[6:0], |READ};
      window_prev_reg <= window;
    end
  end
  assign window = read_pipe_reg[READ_PULSE_SEL];

  assign wb_req = WB_CYC_I & WB_STB_I & ~WB_ACK_O;
  assign wb_wr = wb_req & WB_WE_I;
  assign burst_clr = wb_wr & (WB_ADR_I == sdc_pkg::OFS_CTRL) & WB_SEL_I[0]
    & WB_DAT_I[sdc_pkg::CTRL_BCLR_BIT];

  // start-of-data pulse and sticky burst detect, set beats clear
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      armed_reg <= 1'b0;
      READ_VALID_START <= 1'b0;
      BURST_SEEN <= 1'b0;
    end else if (CE) begin
      READ_VALID_START <= armed_reg & window & cap_rise;
      if (window & ~window_prev_reg) begin
        armed_reg <= 1'b1;
      end else if (~window | cap_rise) begin
        armed_reg <= 1'b0;
      end
      if (window & cap_rise) begin
        BURST_SEEN <= 1'b1;
      end else if (burst_clr) begin
        BURST_SEEN <= 1'b0;
      end
    end
  end

  // register writes
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      ctrl_reg <= sdc_pkg::CTRL_RESET;
      sw_code_reg <= sdc_pkg::CODE_RESET;
    end else if (CE && wb_wr) begin
      if (WB_ADR_I == sdc_pkg::OFS_CTRL && WB_SEL_I[0]) begin
        ctrl_reg <= {29'h0000_0000, WB_DAT_I[2], 1'b0, WB_DAT_I[0]};
      end
      if (WB_ADR_I == sdc_pkg::OFS_CODE) begin
        if (WB_SEL_I[0]) begin
          sw_code_reg[7:0] <= WB_DAT_I[7:0];
        end
        if (WB_SEL_I[1]) begin
          sw_code_reg[8] <= WB_DAT_I[8];
        end
      end
    end
  end

  // bus answer one cycle after the request, unmapped reads give zero
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      WB_ACK_O <= 1'b0;
      WB_DAT_O <= 32'h0000_0000;
    end else if (CE) begin
      WB_ACK_O <= wb_req;
      WB_DAT_O <= 32'h0000_0000;
      if (wb_req && !WB_WE_I) begin
        case (WB_ADR_I)
          sdc_pkg::OFS_CTRL: WB_DAT_O <= ctrl_reg;
          sdc_pkg::OFS_STATUS: WB_DAT_O <= {21'h00_0000, WR_DELAY_CARRY, RD_DELAY_CARRY,
            BURST_SEEN, 1'b0, FIFO_WR_PTR, 1'b0, FIFO_RD_PTR};
          sdc_pkg::OFS_TAPS: WB_DAT_O <= {20'h0_0000, ws_tap, wd_tap, rd_tap};
          sdc_pkg::OFS_CODE: WB_DAT_O <= {23'h00_0000, code};
          default: WB_DAT_O <= 32'h0000_0000;
        endcase
      end
    end
  end
endmodule // sdc_strobe_delay_control_block
`default_nettype wire

/* File: tb/sdc_assertions.sv */
/* Port checker for the strobe delay control block.
   Assumes a bind to the top module and CE held high by the bench. */
`default_nettype none
module sdc_assertions (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic CE,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [3:0] WB_ADR_I,
  input wire logic [31:0] WB_DAT_I,
  input wire logic WB_ACK_O,
  input wire logic READ_CAPTURE_CLK,
  input wire logic [2:0] FIFO_RD_PTR,
  input wire logic [2:0] FIFO_WR_PTR,
  input wire logic [41:0] PIN_RD_PTR,
  input wire logic [41:0] PIN_WR_PTR,
  input wire logic BURST_SEEN
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_N || !CE);
  property p_ack_next; WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O; endproperty
  a_ack_next: assert property (p_ack_next) else $error("ack not next cycle");
  property p_ack_drop; WB_ACK_O |=> !WB_ACK_O; endproperty
  a_ack_drop: assert property (p_ack_drop) else $error("ack longer than one cycle");
  property p_pin_rd; PIN_RD_PTR == {14{FIFO_RD_PTR}}; endproperty
  a_pin_rd: assert property (p_pin_rd) else $error("pin rd ptr differs");
  property p_pin_wr; PIN_WR_PTR == {14{FIFO_WR_PTR}}; endproperty
  a_pin_wr: assert property (p_pin_wr) else $error("pin wr ptr differs");
  property p_rd_step;
    $changed(FIFO_RD_PTR) |-> FIFO_RD_PTR == $past(FIFO_RD_PTR) + 3'h1;
  endproperty
  a_rd_step: assert property (p_rd_step) else $error("rd ptr jump");
  property p_wr_step;
    $changed(FIFO_WR_PTR) |-> FIFO_WR_PTR == $past(FIFO_WR_PTR) + 3'h1;
  endproperty
  a_wr_step: assert property (p_wr_step) else $error("wr ptr jump");
  property p_wr_cause; $rose(READ_CAPTURE_CLK) |-> ##[1:2] $changed(FIFO_WR_PTR); endproperty
  a_wr_cause: assert property (p_wr_cause) else $error("wr ptr missed edge");
  property p_burst_fall;
    $fell(BURST_SEEN) |-> $past(WB_CYC_I && WB_STB_I && WB_WE_I && WB_ADR_I == 4'h0
      && WB_DAT_I[1]);
  endproperty
  a_burst_fall: assert property (p_burst_fall) else $error("burst flag lost");
endmodule // sdc_assertions
`default_nettype wire

/* File: tb/sdc_mem_model.sv */
/* Memory side model: edge clock and strobe bursts of a given beat count.
   Assumes the bench pulses go for one cycle with beats set. */
`default_nettype none
module sdc_mem_model (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic go,
  input wire logic [3:0] beats,
  output logic STROBE,
  output logic EDGE_CLK
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] ph_reg;
  logic [5:0] cnt_reg;
  // no spare pin of this group is tied high, none modelled
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) ph_reg <= 2'h0;
    else ph_reg <= ph_reg + 2'h1;
  end
  assign EDGE_CLK = ph_reg[1];
  // strobe parked low outside a burst
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) cnt_reg <= 6'h00;
    else if (go) cnt_reg <= {beats, 2'h0};
    else if (cnt_reg != 6'h00) cnt_reg <= cnt_reg - 6'h01;
  end
  assign STROBE = cnt_reg[1];
endmodule // sdc_mem_model
`default_nettype wire

/* File: tb/sdc_strobe_delay_control_block_tb.sv */
/* Bench: register, margin and read burst sequences over Wishbone.
   Assumes the package, design, model and checker compiled first. */
`default_nettype none
module sdc_strobe_delay_control_block_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic CLK, RST_N, STROBE, EDGE_CLK, go, WB_CYC_I, WB_STB_I, WB_WE_I, WB_ACK_O;
  logic READ_CAPTURE_CLK, WRITE_STROBE_CLK, WRITE_DATA_CLK, READ_VALID_START;
  logic BURST_SEEN, RD_DELAY_CARRY, WR_DELAY_CARRY, chk_on, ep;
  logic [1:0] READ;
  logic [2:0] READ_PULSE_SEL, FIFO_RD_PTR, FIFO_WR_PTR, nrd;
  logic [3:0] WB_ADR_I, beats;
  logic [8:0] DELAY_SETTING_IN, DELAY_SETTING_OUT;
  logic [15:0] sh, es;
  logic [31:0] WB_DAT_I, WB_DAT_O, q;
  logic [41:0] PIN_RD_PTR, PIN_WR_PTR;
  sdc_pkg::sdc_margin_t [2:0] mg;
  int n_errors = 0, compares = 0, nv = 0, ncr = 0, nwc = 0;
  sdc_strobe_delay_control_block u_sdc_strobe_delay_control_block (.CLK, .RST_N, .CE(1'b1),
    .STROBE, .EDGE_CLK, .READ, .READ_PULSE_SEL, .RD_MARGIN(mg[0]), .WR_MARGIN(mg[1]),
    .WLVL(mg[2]), .DELAY_SETTING_IN, .WB_CYC_I, .WB_STB_I, .WB_WE_I, .WB_ADR_I,
    .WB_SEL_I(4'hF), .WB_DAT_I, .WB_DAT_O, .WB_ACK_O, .READ_CAPTURE_CLK, .WRITE_STROBE_CLK,
    .WRITE_DATA_CLK, .FIFO_RD_PTR, .FIFO_WR_PTR, .PIN_RD_PTR, .PIN_WR_PTR, .READ_VALID_START,
    .BURST_SEEN, .RD_DELAY_CARRY, .WR_DELAY_CARRY, .DELAY_SETTING_OUT);
  sdc_mem_model u_sdc_mem_model (.CLK, .RST_N, .go, .beats, .STROBE, .EDGE_CLK);
  task automatic give_verdict;
    if (n_errors == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [41:0] got, input logic [41:0] exp);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected %s: expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wb(input logic we, input logic [3:0] a, input logic [31:0] d);
    @(posedge CLK);
    WB_CYC_I <= 1'b1;
    WB_STB_I <= 1'b1;
    WB_WE_I <= we;
    WB_ADR_I <= a;
    WB_DAT_I <= d;
    do @(posedge CLK); while (WB_ACK_O !== 1'b1);
    q = WB_DAT_O;
    WB_CYC_I <= 1'b0;
    WB_STB_I <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] e, input string nm);
    wb(1'b0, a, 32'h0);
    chk(nm, q, e);
  endtask
  task automatic stp(input int i, input logic d);
    @(posedge CLK);
    mg[i].dir <= d;
    mg[i].step <= 1'b1;
    @(posedge CLK);
    mg[i].step <= 1'b0;
    repeat (3) @(posedge CLK);
  endtask
  task automatic ld;
    @(posedge CLK);
    mg <= 9'h000;
    @(posedge CLK);
    mg <= 9'h124;
    @(posedge CLK);
  endtask
  task automatic burst(input logic [2:0] sel, input logic [3:0] n, input logic c);
    @(posedge CLK);
    READ_PULSE_SEL <= sel;
    READ <= 2'h1;
    beats <= n;
    repeat (10) @(posedge CLK);
    go <= 1'b1;
    chk_on <= c;
    @(posedge CLK);
    go <= 1'b0;
    repeat (4 * n + 24) @(posedge CLK);
    READ <= 2'h0;
    chk_on <= 1'b0;
    repeat (4) @(posedge CLK);
  endtask
  always @(posedge CLK) begin
    sh <= {sh[14:0], STROBE};
    es <= {es[14:0], EDGE_CLK};
    ep <= EDGE_CLK;
    if (EDGE_CLK === 1'b1 && ep === 1'b0) nrd <= nrd + 3'h1;
    if (READ_VALID_START === 1'b1) nv++;
    if (RD_DELAY_CARRY === 1'b1) ncr++;
    if (WR_DELAY_CARRY === 1'b1) nwc++;
    if (chk_on) chk("capture clk", READ_CAPTURE_CLK, sh[9]);
    if (chk_on) chk("strobe clk", WRITE_STROBE_CLK, es[1]);
    if (chk_on) chk("data clk", WRITE_DATA_CLK, es[9]);
  end
  initial begin
    CLK = 1'b0;
    forever #12.5 CLK = ~CLK;
  end
  initial begin
    #500000;
    n_errors++;
    give_verdict;
  end
  initial begin
    {RST_N, go, WB_CYC_I, WB_STB_I, WB_WE_I, chk_on} = 6'h00;
    {READ, READ_PULSE_SEL, WB_ADR_I, beats, WB_DAT_I, sh, es, nrd, ep} = 81'h0;
    mg = 9'h124;
    DELAY_SETTING_IN = 9'h030;
    repeat (2) @(posedge CLK);
    RST_N <= 1'b1;
    rd(4'h0, 32'h1, "ctrl reset");
    rd(4'hC, 32'h30, "code in use");
    rd(4'h8, 32'hCC, "taps loop");
    chk("code out", DELAY_SETTING_OUT, 42'h30);
    wb(1'b1, 4'h0, 32'h5);
    rd(4'h8, 32'h88, "taps sw");
    chk("code out sw", DELAY_SETTING_OUT, 42'h20);
    stp(0, 1'b1);
    stp(1, 1'b0);
    stp(2, 1'b1);
    rd(4'h8, 32'h189, "taps moved");
    ld();
    rd(4'h8, 32'h88, "taps loaded");
    repeat (8) stp(0, 1'b1);
    chk("rd carry", ncr, 42'h1);
    ld();
    repeat (9) stp(1, 1'b0);
    chk("wr carry", nwc, 42'h1);
    ld();
    rd(4'h2, 32'h0, "unmapped");
    burst(3'h0, 4'h5, 1'b1);
    burst(3'h7, 4'h5, 1'b1);
    chk("valid starts", nv, 42'h2);
    chk("burst seen", BURST_SEEN, 42'h1);
    chk("wr ptr", FIFO_WR_PTR, 42'h2);
    chk("pin wr ptr", PIN_WR_PTR, {14{3'h2}});
    chk("rd ptr", FIFO_RD_PTR, nrd);
    chk("pin rd ptr", PIN_RD_PTR, {14{nrd}});
    wb(1'b1, 4'h0, 32'h7);
    rd(4'h0, 32'h5, "ctrl clear bit");
    chk("burst cleared", BURST_SEEN, 42'h0);
    wb(1'b1, 4'h0, 32'h4);
    burst(3'h3, 4'h3, 1'b0);
    wb(1'b0, 4'h4, 32'h0);
    chk("status", q[10:4], 42'h02);
    wb(1'b1, 4'hC, 32'h1FF);
    rd(4'hC, 32'h1FF, "code written");
    rd(4'h8, 32'hFF, "taps clamped");
    give_verdict;
  end
endmodule // sdc_strobe_delay_control_block_tb
bind sdc_strobe_delay_control_block sdc_assertions u_sdc_assertions (.CLK, .RST_N, .CE,
  .WB_CYC_I, .WB_STB_I, .WB_WE_I, .WB_ADR_I, .WB_DAT_I, .WB_ACK_O, .READ_CAPTURE_CLK,
  .FIFO_RD_PTR, .FIFO_WR_PTR, .PIN_RD_PTR, .PIN_WR_PTR, .BURST_SEEN);
`default_nettype wire
